// file: bsio_ctrl_model.sv
/* memory controller model: commands, late write data, lane strobes.
   assumes the caller waits for each task before the next one. */
`timescale 1ns/1ps
////////////////////////////////////////
module bsio_ctrl_model (
  input  wire        clk,
  output reg         load_strobe_n,
  output reg         rd_wr_sel,
  output reg  [19:0] addr,
  output reg  [35:0] wr_data,
  output wire        byte_strobe_lane0_n,
  output wire        byte_strobe_lane1_n,
  output wire        byte_strobe_lane2_n,
  output wire        byte_strobe_lane3_n
);
  reg [3:0] strb_r;
  assign {byte_strobe_lane3_n, byte_strobe_lane2_n} = strb_r[3:2];
  assign {byte_strobe_lane1_n, byte_strobe_lane0_n} = strb_r[1:0];
  initial begin
    load_strobe_n = 1'b1;
    rd_wr_sel = 1'b1;
    addr = 20'h00000;
    wr_data = 36'h000000000;
    strb_r = 4'hF;
  end
  // one command per call keeps commands at least two edges apart
  task rd_cmd(input logic [19:0] a);
    @(posedge clk);
    load_strobe_n <= 1'b0;
    rd_wr_sel <= 1'b1;
    addr <= a;
    @(posedge clk);
    load_strobe_n <= 1'b1;
    addr <= ~a;
  endtask
  task wr_cmd(input logic [19:0] a, input logic [35:0] d0, d1,
              input logic [3:0] s0, s1);
    @(posedge clk);
    load_strobe_n <= 1'b0;
    rd_wr_sel <= 1'b0;
    addr <= a;
    @(posedge clk);
    load_strobe_n <= 1'b1;
    addr <= ~a;
    wr_data <= d0;
    strb_r <= s0;
    @(posedge clk);
    wr_data <= d1;
    strb_r <= s1;
    @(posedge clk);
    // released lines show garbage, not the last beat
    wr_data <= ~d1;
    strb_r <= 4'hF;
  endtask
endmodule

// file: bsio_port.v
/*
 * device side of a burst-of-two separate-io ddr sram port, modelled on a
 * single clock: one clk edge stands for a command edge, and each burst is
 * two beats on consecutive clk cycles (first beat = rising half, second
 * beat = complement half). clocks-stopped is an input that freezes state.
 * assumes the controller spaces commands two cycles apart and finishes
 * all pending work before asserting clk_stop.
 */
`timescale 1ns/1ps
`include "bsio_regs.vh"

module bsio_port (
  clk,
  rst,
  clk_stop,
  x18_mode,
  out_clk_tied,
  load_strobe_n,
  rd_wr_sel,
  addr,
  wr_data,
  byte_strobe_lane0_n,
  byte_strobe_lane1_n,
  byte_strobe_lane2_n,
  byte_strobe_lane3_n,
  rd_ready,
  rd_data,
  rd_data_oe,
  rd_beat_out,
  out_src_in_clk,
  idle_cycle
);
  input  wire                     clk;
  input  wire                     rst;
  input  wire                     clk_stop;
  input  wire                     x18_mode;
  input  wire                     out_clk_tied;
  input  wire                     load_strobe_n;
  input  wire                     rd_wr_sel;
  input  wire [`BSIO_ADDR_W-1:0]  addr;
  input  wire [`BSIO_DATA_W-1:0]  wr_data;
  input  wire                     byte_strobe_lane0_n;
  input  wire                     byte_strobe_lane1_n;
  input  wire                     byte_strobe_lane2_n;
  input  wire                     byte_strobe_lane3_n;
  input  wire                     rd_ready;
  output reg  [`BSIO_DATA_W-1:0]  rd_data;
  output reg                      rd_data_oe;
  output reg                      rd_beat_out;
  output reg                      out_src_in_clk;
  output reg                      idle_cycle;

  localparam ST_IDLE  = 2'h0;
  localparam ST_RD2   = 2'h1;
  localparam ST_WR1   = 2'h2;
  localparam ST_WR2   = 2'h3;

  reg  [1:0]              state_r;
  reg  [1:0]              state_nxt;
  reg  [`BSIO_ADDR_W-1:0] base_r;
  // limitation: only the low address bits index the array; the rest alias
  reg  [`BSIO_DATA_W-1:0] array_r [0:`BSIO_MEM_WORDS-1];

  // write buffer: two most recent beats, each word + lane mask
  reg  [`BSIO_ADDR_W-1:0] wb_addr_r [0:1];
  reg  [`BSIO_DATA_W-1:0] wb_data_r [0:1];
  reg  [`BSIO_LANES-1:0]  wb_mask_r [0:1];
  reg  [1:0]              wb_vld_r;

  wire [`BSIO_LANES-1:0]  strobe_n;
  wire [`BSIO_LANES-1:0]  lane_en;
  wire [`BSIO_ADDR_W-1:0] cmd_addr;
  wire [`BSIO_ADDR_W-1:0] rd_addr;
  wire [`BSIO_ADDR_W-1:0] wr_addr;
  wire                    rd_start;
  wire                    wr_start;
  wire                    rd_beat;
  wire                    wr_beat;
  wire [`BSIO_DATA_W-1:0] rd_word;
  wire                    buf_in_ready;
  wire                    buf_out_valid;
  wire [`BSIO_DATA_W-1:0] buf_out_data;
  wire                    run;

  //////////////////////////////////////////////////////////////////////
  // address masking and helpers

  // word address width depends on organisation
  function [`BSIO_ADDR_W-1:0] org_addr;
    input [`BSIO_ADDR_W-1:0] a;
    input                    x18;
    begin
      if (x18)
        org_addr = a;
      else
        org_addr = {1'b0, a[`BSIO_ADDR_W_X36-1:0]};
    end
  endfunction

  // only the low 10 bits index the modelled array
  function [`BSIO_MEM_AW-1:0] mem_idx;
    input [`BSIO_ADDR_W-1:0] a;
    begin
      mem_idx = a[`BSIO_MEM_AW-1:0];
    end
  endfunction

  // start + 1; the carry out of the top bit is dropped on purpose, so a
  // burst that starts on the last word wraps to word zero
  function [`BSIO_ADDR_W-1:0] next_addr;
    input [`BSIO_ADDR_W-1:0] a;
    input                    x18;
    begin
      next_addr = org_addr(a + `BSIO_BURST_STEP, x18);
    end
  endfunction

  // merge a write beat into a word lane by lane
  function [`BSIO_DATA_W-1:0] merge;
    input [`BSIO_DATA_W-1:0] old_w;
    input [`BSIO_DATA_W-1:0] new_w;
    input [`BSIO_LANES-1:0]  en;
    integer i;
    begin
      merge = old_w;
      for (i = 0; i < `BSIO_LANES; i = i + 1)
        if (en[i])
          merge[i*`BSIO_LANE_W +: `BSIO_LANE_W] =
            new_w[i*`BSIO_LANE_W +: `BSIO_LANE_W];
    end
  endfunction

  assign run      = ~clk_stop;
  assign strobe_n = {byte_strobe_lane3_n, byte_strobe_lane2_n,
                     byte_strobe_lane1_n, byte_strobe_lane0_n};
  assign cmd_addr = org_addr(addr, x18_mode);

  //////////////////////////////////////////////////////////////////////
  // lane enables and command decode

  // x18 uses two lanes; upper lanes are forced off
  genvar g;
  generate
    for (g = 0; g < `BSIO_LANES; g = g + 1) begin : g_lane
      if (g < 2) begin : g_lo
        assign lane_en[g] = ~strobe_n[g];
      end else begin : g_hi
        assign lane_en[g] = ~strobe_n[g] & ~x18_mode;
      end
    end
  endgenerate

  // the first write-beat edge carries data, so a command there is refused
  assign rd_start = run & (state_r != ST_WR1) & ~load_strobe_n
                    & rd_wr_sel;
  assign wr_start = run & (state_r != ST_WR1) & ~load_strobe_n
                    & ~rd_wr_sel;

  // reads and writes keep separate beat addresses: a read may start on
  // the second write-beat edge and must not borrow the write's address
  assign rd_addr = (state_r == ST_RD2) ? next_addr(base_r, x18_mode)
                                       : cmd_addr;
  assign wr_addr = (state_r == ST_WR2) ? next_addr(base_r, x18_mode)
                                       : base_r;

  assign rd_beat = rd_start | (run & state_r == ST_RD2);
  assign wr_beat = run & (state_r == ST_WR1 || state_r == ST_WR2);

  //////////////////////////////////////////////////////////////////////
  // read lookup with write-buffer forwarding

  // a read on a write-beat edge sees the buffer before that beat lands
  // newer buffer entry (index 0) is applied last so it wins
  assign rd_word =
    merge(merge(array_r[mem_idx(rd_addr)], wb_data_r[1],
                (wb_vld_r[1] && wb_addr_r[1] == rd_addr)
                ? wb_mask_r[1] : 4'h0),
          wb_data_r[0],
          (wb_vld_r[0] && wb_addr_r[0] == rd_addr)
          ? wb_mask_r[0] : 4'h0);

  //////////////////////////////////////////////////////////////////////
  // burst sequencer

  always @* begin
    state_nxt = state_r;
    case (state_r)
      // a command on the second write-beat edge is legal and starts at once
      ST_IDLE, ST_WR2: begin
        if (rd_start)
          state_nxt = ST_RD2;
        else if (wr_start)
          state_nxt = ST_WR1;
        else
          state_nxt = ST_IDLE;
      end
      // an idle cycle here does not cut the read short
      ST_RD2: begin
        if (wr_start)
          state_nxt = ST_WR1;
        else
          state_nxt = ST_IDLE;
      end
      ST_WR1:
        state_nxt = ST_WR2;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // a read issued in ST_RD2 would collide; controller spacing forbids it
  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      base_r  <= {`BSIO_ADDR_W{1'b0}};
    end else if (run) begin
      if (rd_start && state_r == ST_RD2)
        state_r <= ST_IDLE;
      else
        state_r <= state_nxt;
      if (rd_start | wr_start)
        base_r <= cmd_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write buffer: newest beat enters slot 0, slot 1 retires to the array

  always @(posedge clk) begin
    if (rst) begin
      wb_vld_r <= 2'h0;
    end else if (run && wr_beat) begin
      if (wb_vld_r[1])
        array_r[mem_idx(wb_addr_r[1])] <=
          merge(array_r[mem_idx(wb_addr_r[1])], wb_data_r[1],
                wb_mask_r[1]);
      wb_addr_r[1] <= wb_addr_r[0];
      wb_data_r[1] <= wb_data_r[0];
      wb_mask_r[1] <= wb_mask_r[0];
      wb_vld_r[1]  <= wb_vld_r[0];
      wb_addr_r[0] <= wr_addr;
      wb_data_r[0] <= wr_data;
      wb_mask_r[0] <= lane_en;
      // all strobes high aborts the beat
      wb_vld_r[0]  <= |lane_en;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data path through the two-entry buffer

  // beats are lost only if the receiver stalls past two buffered beats
  bsio_skid u_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rd_beat & buf_in_ready),
    .in_ready  (buf_in_ready),
    .in_data   (rd_word),
    .out_valid (buf_out_valid),
    .out_ready (rd_ready & run),
    .out_data  (buf_out_data)
  );

  // a stall clears the beat flag, so the beat after a stall shows as first
  // outputs registered; frozen while clocks are stopped
  always @(posedge clk) begin
    if (rst) begin
      rd_data        <= `BSIO_OUT_ZERO;
      rd_data_oe     <= 1'b0;
      rd_beat_out    <= 1'b0;
      out_src_in_clk <= 1'b0;
      idle_cycle     <= 1'b0;
    end else if (run) begin
      out_src_in_clk <= out_clk_tied;
      idle_cycle     <= load_strobe_n;
      if (buf_out_valid & rd_ready) begin
        rd_data     <= buf_out_data;
        rd_data_oe  <= 1'b1;
        rd_beat_out <= ~rd_beat_out;
      end else begin
        // float when no beat is due; bus value is don't care
        rd_data_oe  <= 1'b0;
        rd_beat_out <= 1'b0;
      end
    end
  end
endmodule

// file: bsio_port_assertions.sv
/* timing checks on the bsio_port pins.
   assumes one clk and a synchronous active-high rst. */
`timescale 1ns/1ps
`include "bsio_regs.vh"
////////////////////////////////////////
module bsio_port_chk (
  input wire                    clk,
  input wire                    rst,
  input wire                    clk_stop,
  input wire                    out_clk_tied,
  input wire                    load_strobe_n,
  input wire                    rd_wr_sel,
  input wire                    rd_ready,
  input wire [`BSIO_DATA_W-1:0] rd_data,
  input wire                    rd_data_oe,
  input wire                    rd_beat_out,
  input wire                    out_src_in_clk,
  input wire                    idle_cycle
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd;
    !load_strobe_n && rd_wr_sel && !clk_stop && rd_ready;
  endsequence
  property p_idle;
    !rst && load_strobe_n && !clk_stop |=> idle_cycle;
  endproperty
  property p_load;
    !rst && !load_strobe_n && !clk_stop |=> !idle_cycle;
  endproperty
  // receiver must stay ready, else the beats legally slip
  property p_rd_lat;
    s_rd ##1 (rd_ready && !clk_stop) [*2] |->
      (rd_data_oe && rd_beat_out) ##1 (rd_data_oe && !rd_beat_out);
  endproperty
  // six clear cycles drain even a full buffer
  property p_float;
    ((load_strobe_n || !rd_wr_sel) && rd_ready && !clk_stop) [*6]
      |-> !rd_data_oe;
  endproperty
  property p_src;
    !clk_stop |=> out_src_in_clk == $past(out_clk_tied);
  endproperty
  property p_hold;
    clk_stop |=> $stable(rd_data) && $stable(rd_data_oe);
  endproperty
  property p_stall;
    rd_data_oe && !rd_ready && !clk_stop |=> $stable(rd_data);
  endproperty
  property p_beat;
    rd_beat_out |-> rd_data_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag missing");
  a_load: assert property (p_load) else $error("idle flag on load");
  a_rd_lat: assert property (p_rd_lat) else $error("read beats late");
  a_float: assert property (p_float) else $error("output not off");
  a_src: assert property (p_src) else $error("clock source wrong");
  a_hold: assert property (p_hold) else $error("output moved");
  a_stall: assert property (p_stall) else $error("stalled beat lost");
  a_beat: assert property (p_beat) else $error("beat flag idle");
  c_rd: cover property (s_rd);
  c_wr: cover property (!load_strobe_n && !rd_wr_sel && !clk_stop);
  c_stall: cover property (rd_data_oe && !rd_ready);
endmodule
bind bsio_port bsio_port_chk i_chk (.clk(clk), .rst(rst),
  .clk_stop(clk_stop), .out_clk_tied(out_clk_tied),
  .load_strobe_n(load_strobe_n), .rd_wr_sel(rd_wr_sel),
  .rd_ready(rd_ready), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
  .rd_beat_out(rd_beat_out), .out_src_in_clk(out_src_in_clk),
  .idle_cycle(idle_cycle));

// file: bsio_regs.vh
/*
 * constants for the burst-of-two separate-io sram command port:
 * word layout, lane positions, burst and buffer figures.
 * assumes inclusion by bare name from the design files.
 */
`ifndef BSIO_REGS_VH
`define BSIO_REGS_VH

`define BSIO_DATA_W        36
`define BSIO_LANE_W        9
`define BSIO_LANES         4
`define BSIO_ADDR_W        20
`define BSIO_ADDR_W_X36    19
`define BSIO_ADDR_W_X18    20
`define BSIO_BURST_LEN     2
`define BSIO_BURST_STEP    20'h00001
`define BSIO_MEM_WORDS     1024
`define BSIO_MEM_AW        10
`define BSIO_WBUF_DEPTH    2
`define BSIO_OUT_ZERO      36'h000000000
`define BSIO_STROBE_OFF    4'hF

`endif

// file: bsio_skid.v
/*
 * two-entry buffer on the read data path: valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "bsio_regs.vh"

module bsio_skid (
  clk,
  rst,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire                     clk;
  input  wire                     rst;
  input  wire                     in_valid;
  output wire                     in_ready;
  input  wire [`BSIO_DATA_W-1:0]  in_data;
  output wire                     out_valid;
  input  wire                     out_ready;
  output wire [`BSIO_DATA_W-1:0]  out_data;

  reg  [`BSIO_DATA_W-1:0] mem_r [0:1];
  reg                     wp_r;
  reg                     rp_r;
  reg  [1:0]              cnt_r;
  wire                    push;
  wire                    pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      if (push & ~pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// file: tb.sv
/* self-checking bench for bsio_port with a controller model.
   assumes bsio_port.v, bsio_skid.v and the checker are compiled. */
`timescale 1ns/1ps
////////////////////////////////////////
module tb;
  logic clk, rst, clk_stop, x18_mode, out_clk_tied, rd_ready;
  wire ld_n, sel, l0, l1, l2, l3, rd_data_oe, rd_beat_out, src, idl;
  wire [19:0] addr;
  wire [35:0] wr_data, rd_data;
  logic [35:0] got [0:3];
  logic [35:0] e0, e1;
  int err_total, n_tests, cyc;
  bsio_ctrl_model mdl (.clk(clk), .load_strobe_n(ld_n), .rd_wr_sel(sel),
    .addr(addr), .wr_data(wr_data), .byte_strobe_lane0_n(l0),
    .byte_strobe_lane1_n(l1), .byte_strobe_lane2_n(l2),
    .byte_strobe_lane3_n(l3));
  bsio_port i_dut (.clk(clk), .rst(rst), .clk_stop(clk_stop),
    .x18_mode(x18_mode), .out_clk_tied(out_clk_tied),
    .load_strobe_n(ld_n), .rd_wr_sel(sel), .addr(addr),
    .wr_data(wr_data), .byte_strobe_lane0_n(l0),
    .byte_strobe_lane1_n(l1), .byte_strobe_lane2_n(l2),
    .byte_strobe_lane3_n(l3), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .rd_beat_out(rd_beat_out),
    .out_src_in_clk(src), .idle_cycle(idl));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task wrap_up;
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  task chk(input string nm, input logic [35:0] x, g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  // a beat counts only when offered and taken on the same edge
  task collect(input int n, input int st);
    int k;
    k = 0;
    for (int i = 0; i < 16 && k < n; i++) begin
      @(posedge clk);
      if (i == st) rd_ready <= 1'b1;
      @(negedge clk);
      if (i == 1) chk("idle", 36'h0, 36'(idl));
      if (rd_data_oe === 1'b1 && rd_ready === 1'b1) begin
        got[k] = rd_data;
        chk("flag", 36'(k % 2 == 0), 36'(rd_beat_out));
        k++;
      end
    end
    chk("beats", 36'(n), 36'(k));
  endtask
  task rd_chk(input logic [19:0] a, input logic [35:0] m, input int st);
    fork
      mdl.rd_cmd(a);
      collect(2, st);
    join
    chk("beat0", e0 & m, got[0] & m);
    chk("beat1", e1 & m, got[1] & m);
  endtask
  task t_lanes;
    e0 = 36'h123456789;
    e1 = 36'h9ABCDEF01;
    mdl.wr_cmd(20'h00010, e0, e1, 4'h0, 4'h0);
    rd_chk(20'h00010, 36'hFFFFFFFFF, -1);
    for (int i = 0; i < 4; i++) begin
      mdl.wr_cmd(20'h00010, 36'hFFFFFFFFF, 36'h0, 4'hF ^ (4'h1 << i), 4'hF);
      e0 = e0 | (36'h1FF << (9 * i));
      rd_chk(20'h00010, 36'hFFFFFFFFF, -1);
    end
    mdl.wr_cmd(20'h00012, ~e0, ~e1, 4'h0, 4'h0);
    fork
      begin
        mdl.rd_cmd(20'h00010);
        mdl.rd_cmd(20'h00012);
      end
      collect(4, -1);
    join
    chk("b2b0", e0, got[0]);
    chk("b2b1", e1, got[1]);
    chk("b2b2", ~e0, got[2]);
    chk("b2b3", ~e1, got[3]);
    mdl.wr_cmd(20'h80030, e0, e1, 4'h0, 4'h0);
    rd_chk(20'h00030, 36'hFFFFFFFFF, -1);
  endtask
  task t_x18;
    @(posedge clk);
    x18_mode <= 1'b1;
    e0 = 36'h00002AAAA;
    e1 = 36'h000015555;
    mdl.wr_cmd(20'h00020, e0, e1, 4'h0, 4'h0);
    mdl.wr_cmd(20'h00020, 36'hFFFFFFFFF, 36'hFFFFFFFFF, 4'h3, 4'hE);
    e1 = e1 | 36'h0000001FF;
    rd_chk(20'h00020, 36'h00003FFFF, -1);
    @(posedge clk);
    rd_ready <= 1'b0;
    rd_chk(20'h00020, 36'h00003FFFF, 6);
  endtask
  task t_stop;
    @(posedge clk);
    out_clk_tied <= 1'b1;
    clk_stop <= 1'b1;
    mdl.rd_cmd(20'h00010);
    clk_stop <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      chk("oe", 36'h0, 36'(rd_data_oe));
    end
    chk("src", 36'h1, 36'(src));
    chk("idle", 36'h1, 36'(idl));
    rd_chk(20'h00020, 36'h00003FFFF, -1);
  endtask
  initial begin
    rst = 1'b1;
    clk_stop = 1'b0;
    x18_mode = 1'b0;
    out_clk_tied = 1'b0;
    rd_ready = 1'b1;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_lanes();
    t_x18();
    t_stop();
    wrap_up();
  end
endmodule
